// [logic/dtc_top.v]
// dual timer/counter with apb register access
// assumes count and irq pins synchronous to CLK_IN
// and a wait-free apb master for all registers
`timescale 1ns/1ps
`include "dtc_map.vh"
// Function
// R1: four modes per timer via mode pair
// R2: mode 0 is 13-bit, high plus low five
// R3: rollover sets the overflow flag
// R4: count when run and (no gate or pin high)
// R5: setting run never alters the count
// R6: gate bits at mode bits 7 and 3
// R7: mode 1 uses full 16 bits
// R8: mode 2 low byte reloads from high
// R9: timer 1 in mode 3 holds count
// R10: timer 0 mode 3 low byte own counter
// R11: split high byte counts cycles, uses run/flag one
// R12: timer 1 restarts leaving its mode 3
// R13: tick is osc/6 or osc/12, or pin
// R14: software sets and clears run bits
// R15: flags cleared on vector or by software
// R16: type bit picks edge or level trigger
module dtc_top (
   // clock and reset
   input  wire        CLK_IN,
   input  wire        RST_B_IN,
   // apb slave
   input  wire        PSEL_IN,
   input  wire        PENABLE_IN,
   input  wire        PWRITE_IN,
   input  wire [11:0] PADDR_IN,
   input  wire [31:0] PWDATA_IN,
   output reg  [31:0] PRDATA_OUT,
   output reg         PREADY_OUT,
   output reg         PSLVERR_OUT,
   // pins
   input  wire        COUNT_INPUT_PIN_ZERO_IN,
   input  wire        COUNT_INPUT_PIN_ONE_IN,
   input  wire        EXTERNAL_IRQ_PIN_ZERO_IN,
   input  wire        EXTERNAL_IRQ_PIN_ONE_IN,
   // interrupt vector acknowledges from the core
   input  wire [3:0]  VECTOR_ACK_IN,   // 0 ovf0, 1 ovf1, 2 ext0, 3 ext1
   // flags to interrupt logic
   output reg         OVERFLOW_FLAG_ZERO_OUT,
   output reg         OVERFLOW_FLAG_ONE_OUT,
   output reg         EXT_IRQ_FLAG_ZERO_OUT,
   output reg         EXT_IRQ_FLAG_ONE_OUT
);
   // ******************************************
   // state
   // ******************************************
   // the two bytes below hold the control part of the software
   // view: mode nibbles and run/flag/type bits;
   // the count words live inside the units.
   // pin history starts high, so a pin resting
   // idle after reset is no falling edge.
   // the divide select sits in its own word
   // and picks the tick for both timers.
   // run bits gate counting, never load it.
   reg  [7:0]  timer_mode_register_q;     // gate, source, mode pair x2
   reg  [7:0]  timer_run_flag_control_q;  // run bits, flags, type bits
   reg  [7:0]  timer_run_flag_control_d;
   reg         fast_q;                    // 1 = divide by 6
   reg  [1:0]  pin_q;                     // previous count pin levels
   reg  [1:0]  irq_q;                     // previous irq pin levels
   wire        tick_w;                    // machine cycle pulse
   wire [15:0] cnt0_w;
   wire [15:0] cnt1_w;
   wire        ovf0_w;
   wire        ovf0h_w;
   wire        ovf1_w;
   wire        ovf1h_w;
   wire        split_w;                   // timer 0 in mode 3
   wire [1:0]  src_w;                     // source pulses per timer
   wire [1:0]  en_w;                      // gated count enables
   wire [1:0]  ext_edge_w;
   wire        setup_w;
   wire        wr_w;
   wire        wr_cnt0_w;
   wire        wr_cnt1_w;
   wire [1:0]  irq_pin_w;
   wire [1:0]  cnt_pin_w;
   // ******************************************
   // helpers
   // ******************************************
   // one compare per offset; it serves writes
   // and the error response, while the read mux
   // has its own case, so a new register needs an entry in each place.
   function hit;  // address decode
      input [11:0] a;
      input [11:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction
   // a transfer is answered the cycle after its
   // setup: ready is high in the first access
   // cycle and a write lands on that edge.
   // no wait states are ever inserted.
   assign setup_w   = PSEL_IN && !PENABLE_IN;
   // write strobe: access cycle with ready
   assign wr_w      = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT;
   // count writes go straight into the units
   assign wr_cnt0_w = wr_w && hit(PADDR_IN, `DTC_OFS_CNT0);
   assign wr_cnt1_w = wr_w && hit(PADDR_IN, `DTC_OFS_CNT1);
   // pins gathered by timer index
   assign irq_pin_w = {EXTERNAL_IRQ_PIN_ONE_IN, EXTERNAL_IRQ_PIN_ZERO_IN};
   assign cnt_pin_w = {COUNT_INPUT_PIN_ONE_IN, COUNT_INPUT_PIN_ZERO_IN};
   // timer 0 in mode 3 splits into two bytes
   assign split_w   = (timer_mode_register_q[1:0] == 2'd3);
   // ******************************************
   // source, gate and edge detection per timer
   // ******************************************
   // with the source bit set a unit counts
   // falling pin events, at most one a clock,
   // so a pin level must hold a clock each.
   // otherwise it counts machine-cycle ticks.
   // the gate lets a high irq pin enable the
   // count, which measures a high pulse width.
   genvar i;
   generate
      for (i = 0; i < 2; i = i + 1) begin : g_src
         // pin counts falling events, else machine cycles R13
         assign src_w[i] = timer_mode_register_q[4*i + `DTC_SRC_BIT] ?
                           (pin_q[i] && !cnt_pin_w[i]) : tick_w;
         // run and (gate off or irq pin high) R4 R6
         assign en_w[i] = src_w[i] &&
                          timer_run_flag_control_q[`DTC_RUN0_BIT + 2*i] &&
                          (!timer_mode_register_q[4*i + `DTC_GATE_BIT] || irq_pin_w[i]);
         // irq pin falling edge for edge mode
         assign ext_edge_w[i] = irq_q[i] && !irq_pin_w[i];
      end
   endgenerate
   // ******************************************
   // pin history
   // ******************************************
   // one flop per pin, compared with the live
   // level to find falling edges; pins are
   // taken as already synchronous.
   always @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         // idle high, no false edge after reset
         pin_q <= 2'b11;
         irq_q <= 2'b11;
      end else begin
         pin_q <= cnt_pin_w;
         irq_q <= irq_pin_w;
      end
   end
   // ******************************************
   // units
   // ******************************************
   // one shared divider makes the tick for
   // both timers; it runs freely, so the first
   // tick after a run bit is set may come
   // anywhere in one divide period.
   // nothing resets its phase but reset.
   dtc_prescale u_pre (
      .clk_in   (CLK_IN),
      .rst_b_in (RST_B_IN),
      .fast_in  (fast_q),
      .tick_out (tick_w)
   );
   // timer 0 is the only unit that splits;
   // its high byte then ignores gate and source.
   // timer 0; split high byte runs from run bit one on cycles R11
   dtc_unit u_t0 (
      .clk_in     (CLK_IN),
      .rst_b_in   (RST_B_IN),
      .mode_in    (timer_mode_register_q[1:0]),
      .cnt_en_in  (en_w[0]),
      .hi_en_in   (tick_w && timer_run_flag_control_q[`DTC_RUN1_BIT]),
      .split_in   (split_w),
      .wr_in      (wr_cnt0_w),
      .wdata_in   (PWDATA_IN[15:0]),
      .cnt_out    (cnt0_w),
      .ovf_lo_out (ovf0_w),
      .ovf_hi_out (ovf0h_w)
   );
   // timer 1 still counts while timer 0 is
   // split, but its overflow sets no flag.
   // timer 1 holds in mode 3, resumes on leaving it R9 R12
   dtc_unit u_t1 (
      .clk_in     (CLK_IN),
      .rst_b_in   (RST_B_IN),
      .mode_in    (timer_mode_register_q[5:4]),
      .cnt_en_in  (en_w[1] && timer_mode_register_q[5:4] != 2'd3),
      .hi_en_in   (1'b0),
      .split_in   (1'b0),
      .wr_in      (wr_cnt1_w),
      .wdata_in   (PWDATA_IN[15:0]),
      .cnt_out    (cnt1_w),
      .ovf_lo_out (ovf1_w),
      .ovf_hi_out (ovf1h_w)
   );
   // ******************************************
   // control register next value
   // ******************************************
   // step order is the priority: software
   // write, then vector clears, then hardware
   // sets, so an event meeting a clear is kept.
   // in level mode the ext flag copies the
   // inverted pin and cannot be cleared.
   // the type bit used is the stored one.
   always @* begin
      timer_run_flag_control_d = timer_run_flag_control_q;
      // default above holds every bit
      // software write of all bits, run bits included R14 R5
      if (wr_w && hit(PADDR_IN, `DTC_OFS_CTRL)) begin
         timer_run_flag_control_d = PWDATA_IN[7:0];
      end
      // vector acknowledge clears flags R15
      if (VECTOR_ACK_IN[0]) timer_run_flag_control_d[`DTC_OVF0_BIT] = 1'b0;
      if (VECTOR_ACK_IN[1]) timer_run_flag_control_d[`DTC_OVF1_BIT] = 1'b0;
      // ack clears an ext flag in edge mode only
      if (VECTOR_ACK_IN[2] && timer_run_flag_control_q[`DTC_EXT0_BIT]) begin
         timer_run_flag_control_d[`DTC_EXF0_BIT] = 1'b0;
      end
      if (VECTOR_ACK_IN[3] && timer_run_flag_control_q[`DTC_EXT1_BIT]) begin
         timer_run_flag_control_d[`DTC_EXF1_BIT] = 1'b0;
      end
      // hardware sets win over clears R3 R11
      if (ovf0_w) timer_run_flag_control_d[`DTC_OVF0_BIT] = 1'b1;
      // when split, flag one is the high byte's
      if (split_w ? ovf0h_w : ovf1_w) timer_run_flag_control_d[`DTC_OVF1_BIT] = 1'b1;
      // edge mode: latch falling edge; level mode: follow low pin R16
      if (timer_run_flag_control_q[`DTC_EXT0_BIT]) begin
         if (ext_edge_w[0]) timer_run_flag_control_d[`DTC_EXF0_BIT] = 1'b1;
      end else begin
         timer_run_flag_control_d[`DTC_EXF0_BIT] = !irq_pin_w[0];
      end
      if (timer_run_flag_control_q[`DTC_EXT1_BIT]) begin
         if (ext_edge_w[1]) timer_run_flag_control_d[`DTC_EXF1_BIT] = 1'b1;
      end else begin
         timer_run_flag_control_d[`DTC_EXF1_BIT] = !irq_pin_w[1];
      end
   end
   // ******************************************
   // registers and apb
   // ******************************************
   always @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         timer_mode_register_q    <= `DTC_RST_BYTE;
         timer_run_flag_control_q <= `DTC_RST_BYTE;
         fast_q                   <= 1'b0;
         // bus outputs idle low
         PRDATA_OUT               <= 32'h0000_0000;
         PREADY_OUT               <= 1'b0;
         PSLVERR_OUT              <= 1'b0;
         // all flags clear
         OVERFLOW_FLAG_ZERO_OUT   <= 1'b0;
         OVERFLOW_FLAG_ONE_OUT    <= 1'b0;
         EXT_IRQ_FLAG_ZERO_OUT    <= 1'b0;
         EXT_IRQ_FLAG_ONE_OUT     <= 1'b0;
      end else begin
         // flag outputs copy the same next value
         // as the control byte: both move together
         timer_run_flag_control_q <= timer_run_flag_control_d;
         OVERFLOW_FLAG_ZERO_OUT   <= timer_run_flag_control_d[`DTC_OVF0_BIT];
         OVERFLOW_FLAG_ONE_OUT    <= timer_run_flag_control_d[`DTC_OVF1_BIT];
         EXT_IRQ_FLAG_ZERO_OUT    <= timer_run_flag_control_d[`DTC_EXF0_BIT];
         EXT_IRQ_FLAG_ONE_OUT     <= timer_run_flag_control_d[`DTC_EXF1_BIT];
         // mode register and clock config writes R1
         if (wr_w && hit(PADDR_IN, `DTC_OFS_MODE)) begin
            timer_mode_register_q <= PWDATA_IN[7:0];
         end
         // 1 picks the six-clock tick, 0 twelve
         if (wr_w && hit(PADDR_IN, `DTC_OFS_CFG)) begin
            fast_q <= PWDATA_IN[0];
         end
         // read data are taken at setup, so a
         // write in the same transfer is not seen
         // answer one cycle after setup
         PREADY_OUT  <= setup_w;
         PSLVERR_OUT <= 1'b0;
         if (setup_w) begin
            // unmapped: write ignored, read 0
            PSLVERR_OUT <= !(hit(PADDR_IN, `DTC_OFS_MODE) || hit(PADDR_IN, `DTC_OFS_CTRL) ||
                             hit(PADDR_IN, `DTC_OFS_CNT0) || hit(PADDR_IN, `DTC_OFS_CNT1) ||
                             hit(PADDR_IN, `DTC_OFS_CFG));
            // read mux, unused upper bits read 0
            case (PADDR_IN)
               `DTC_OFS_MODE: PRDATA_OUT <= {24'h00_0000, timer_mode_register_q};
               `DTC_OFS_CTRL: PRDATA_OUT <= {24'h00_0000, timer_run_flag_control_q};
               `DTC_OFS_CNT0: PRDATA_OUT <= {16'h0000, cnt0_w};
               `DTC_OFS_CNT1: PRDATA_OUT <= {16'h0000, cnt1_w};
               `DTC_OFS_CFG:  PRDATA_OUT <= {31'h0000_0000, fast_q};
               default:       PRDATA_OUT <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // dtc_top

// [logic/dtc_map.vh]
// constants for the dual timer/counter block: register offsets, field positions, timing
// assumes a 32-bit apb slave, one register per aligned word
`ifndef DTC_MAP_VH
`define DTC_MAP_VH
// ******************************************
// register byte offsets
// ******************************************
`define DTC_OFS_MODE   12'h000
`define DTC_OFS_CTRL   12'h004
`define DTC_OFS_CNT0   12'h008
`define DTC_OFS_CNT1   12'h00C
`define DTC_OFS_CFG    12'h010
`define DTC_OFS_ACK    12'h014
// ******************************************
// mode register fields (per timer nibble)
// ******************************************
`define DTC_GATE_BIT   3
`define DTC_SRC_BIT    2
`define DTC_MODE_HI    1
`define DTC_MODE_LO    0
// ******************************************
// control register fields
// ******************************************
`define DTC_OVF1_BIT   7
`define DTC_RUN1_BIT   6
`define DTC_OVF0_BIT   5
`define DTC_RUN0_BIT   4
`define DTC_EXF1_BIT   3
`define DTC_EXT1_BIT   2
`define DTC_EXF0_BIT   1
`define DTC_EXT0_BIT   0
// ******************************************
// reset values and timing
// ******************************************
`define DTC_RST_BYTE   8'h00
`define DTC_OSC_HZ     50000000
`define DTC_DIV_FAST   4'd6
`define DTC_DIV_SLOW   4'd12
`endif

// [logic/dtc_prescale.v]
// machine-cycle tick generator: one pulse every 6 or 12 clocks
// assumes clk_in is the oscillator
`timescale 1ns/1ps
module dtc_prescale (
   // clock and reset
   input  wire       clk_in,
   input  wire       rst_b_in,
   // divide select: 1 = divide by 6
   input  wire       fast_in,
   // one-cycle tick
   output reg        tick_out
);
`include "dtc_map.vh"
   reg  [3:0] cnt_q;       // oscillator period count
   wire [3:0] last_w;      // terminal count
   assign last_w = fast_in ? (`DTC_DIV_FAST - 4'd1) : (`DTC_DIV_SLOW - 4'd1);
   // ******************************************
   // divider
   // ******************************************
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_q    <= 4'h0;
         tick_out <= 1'b0;
      end else if (cnt_q >= last_w) begin
         cnt_q    <= 4'h0;   // wrap and tick R13
         tick_out <= 1'b1;
      end else begin
         cnt_q    <= cnt_q + 4'h1;
         tick_out <= 1'b0;
      end
   end
endmodule // dtc_prescale

// [logic/dtc_unit.v]
// one 16-bit timer/counter unit with modes 0, 1, 2 and split mode 3
// assumes count enable and writes come from the parent
`timescale 1ns/1ps
module dtc_unit (
   // clock and reset
   input  wire        clk_in,
   input  wire        rst_b_in,
   // control
   input  wire [1:0]  mode_in,     // mode pair
   input  wire        cnt_en_in,   // gated count pulse for low part
   input  wire        hi_en_in,    // separate high byte count (split mode)
   input  wire        split_in,    // low and high bytes independent
   // software write
   input  wire        wr_in,
   input  wire [15:0] wdata_in,
   // state
   output reg  [15:0] cnt_out,
   output reg         ovf_lo_out,  // overflow of the normal/low counter
   output reg         ovf_hi_out   // overflow of split high byte
);
   reg [15:0] cnt_d;
   reg        ovf_lo_d;
   reg        ovf_hi_d;
   // ******************************************
   // next count
   // ******************************************
   always @* begin
      cnt_d    = cnt_out;
      ovf_lo_d = 1'b0;
      ovf_hi_d = 1'b0;
      if (cnt_en_in) begin
         if (split_in || mode_in == 2'd3) begin
            cnt_d[7:0] = cnt_out[7:0] + 8'h01;               // R10
            ovf_lo_d   = (cnt_out[7:0] == 8'hFF);
         end else begin
            case (mode_in)
               2'd0: begin
                  cnt_d[4:0] = cnt_out[4:0] + 5'h01;         // R2
                  if (cnt_out[4:0] == 5'h1F) begin
                     cnt_d[15:8] = cnt_out[15:8] + 8'h01;
                     ovf_lo_d    = (cnt_out[15:8] == 8'hFF); // R3
                  end
               end
               2'd1: begin
                  cnt_d    = cnt_out + 16'h0001;             // R7
                  ovf_lo_d = (cnt_out == 16'hFFFF);          // R3
               end
               default: begin
                  if (cnt_out[7:0] == 8'hFF) begin
                     cnt_d[7:0] = cnt_out[15:8];             // R8
                     ovf_lo_d   = 1'b1;
                  end else begin
                     cnt_d[7:0] = cnt_out[7:0] + 8'h01;
                  end
               end
            endcase
         end
      end
      if (split_in && hi_en_in) begin
         cnt_d[15:8] = cnt_out[15:8] + 8'h01;                // R11
         ovf_hi_d    = (cnt_out[15:8] == 8'hFF);
      end
      if (wr_in) begin
         cnt_d = wdata_in;   // software load wins over counting
      end
   end
   // ******************************************
   // registers
   // ******************************************
   always @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_out    <= 16'h0000;
         ovf_lo_out <= 1'b0;
         ovf_hi_out <= 1'b0;
      end else begin
         cnt_out    <= cnt_d;
         ovf_lo_out <= ovf_lo_d;
         ovf_hi_out <= ovf_hi_d;
      end
   end
endmodule // dtc_unit

// [bench/dtc_pins_model.sv]
// partner: count pins and irq/gate pins in front of the timers
// assumes the bench calls its tasks just after a clock edge
`timescale 1ns/1ps
module dtc_pins_model (
   input  wire       clk_in,       // bench clock
   output reg  [1:0] cnt_pin_out,  // count pins, idle high
   output reg  [1:0] irq_pin_out   // irq and gate pins, idle high
);
   initial begin
      cnt_pin_out = 2'b11;
      irq_pin_out = 2'b11;
   end
   // n falling edges on pin t, each half h clocks long
   task pulse(input int t, input int n, input int h);
      repeat (n) begin
         repeat (h) @(posedge clk_in);
         cnt_pin_out[t] <= 1'b0;
         repeat (h) @(posedge clk_in);
         cnt_pin_out[t] <= 1'b1;
      end
   endtask
   // set an irq/gate pin level
   task irq(input int t, input logic v);
      @(posedge clk_in);
      irq_pin_out[t] <= v;
   endtask
endmodule // dtc_pins_model

// [bench/dtc_top_asserts.sv]
// checker: apb timing and causes of flag changes
// assumes it is bound into dtc_top, single clock domain
`timescale 1ns/1ps
`include "dtc_map.vh"
module dtc_top_asserts (
   input wire        CLK_IN,
   input wire        RST_B_IN,
   input wire        PSEL_IN,
   input wire        PENABLE_IN,
   input wire        PWRITE_IN,
   input wire [11:0] PADDR_IN,
   input wire [31:0] PRDATA_OUT,
   input wire        PREADY_OUT,
   input wire        PSLVERR_OUT,
   input wire        EXTERNAL_IRQ_PIN_ZERO_IN,
   input wire [3:0]  VECTOR_ACK_IN,
   input wire        OVERFLOW_FLAG_ZERO_OUT,
   input wire        OVERFLOW_FLAG_ONE_OUT,
   input wire        EXT_IRQ_FLAG_ZERO_OUT
);
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // ****************
   // helper history
   // ****************
   wire        wr_ctrl = PSEL_IN && PENABLE_IN && PWRITE_IN && PREADY_OUT
                         && PADDR_IN == `DTC_OFS_CTRL;  // control write
   logic [2:0] clr0_q;  // recent clear causes, timer 0
   logic [2:0] clr1_q;  // recent clear causes, timer 1
   logic [5:0] pin0_q;  // recent irq pin levels
   // shift causes in each clock
   always @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         clr0_q <= 3'h0;
         clr1_q <= 3'h0;
         pin0_q <= 6'h3F;
      end else begin
         clr0_q <= {clr0_q[1:0], VECTOR_ACK_IN[0] | wr_ctrl};
         clr1_q <= {clr1_q[1:0], VECTOR_ACK_IN[1] | wr_ctrl};
         pin0_q <= {pin0_q[4:0], EXTERNAL_IRQ_PIN_ZERO_IN};
      end
   end
   sequence s_setup;
      PSEL_IN && !PENABLE_IN;
   endsequence
   sequence s_access;
      PSEL_IN && PENABLE_IN;
   endsequence
   chk_ready_after_setup : assert property (s_setup |=> PREADY_OUT)
      else $error("no ready after setup");
   chk_ready_in_access : assert property (PREADY_OUT |-> s_access)
      else $error("ready outside access");
   chk_error_with_ready : assert property (PSLVERR_OUT |-> PREADY_OUT)
      else $error("error without ready");
   chk_unmapped_error : assert property (PREADY_OUT && PADDR_IN == `DTC_OFS_ACK
      |-> PSLVERR_OUT && (PWRITE_IN || PRDATA_OUT == 32'h0))
      else $error("unmapped access not refused");
   chk_mapped_no_error : assert property (PREADY_OUT && PADDR_IN < `DTC_OFS_ACK
      |-> !PSLVERR_OUT)
      else $error("mapped access refused");
   chk_ovf0_clear_cause : assert property ($fell(OVERFLOW_FLAG_ZERO_OUT)
      |-> clr0_q != 3'h0)
      else $error("overflow flag 0 cleared without cause");
   chk_ovf1_clear_cause : assert property ($fell(OVERFLOW_FLAG_ONE_OUT)
      |-> clr1_q != 3'h0)
      else $error("overflow flag 1 cleared without cause");
   chk_ext0_rise_cause : assert property ($rose(EXT_IRQ_FLAG_ZERO_OUT)
      |-> pin0_q != 6'h3F)
      else $error("irq flag 0 set without low pin");
   chk_reset_clear : assert property ($rose(RST_B_IN) |-> !PREADY_OUT
      && !OVERFLOW_FLAG_ZERO_OUT && !OVERFLOW_FLAG_ONE_OUT && !EXT_IRQ_FLAG_ZERO_OUT)
      else $error("outputs not clear after reset");
endmodule // dtc_top_asserts
bind dtc_top dtc_top_asserts u_chk (.CLK_IN, .RST_B_IN, .PSEL_IN, .PENABLE_IN,
   .PWRITE_IN, .PADDR_IN, .PRDATA_OUT, .PREADY_OUT, .PSLVERR_OUT,
   .EXTERNAL_IRQ_PIN_ZERO_IN, .VECTOR_ACK_IN, .OVERFLOW_FLAG_ZERO_OUT,
   .OVERFLOW_FLAG_ONE_OUT, .EXT_IRQ_FLAG_ZERO_OUT);

// [bench/dual_timer_counter_test.sv]
// testbench: dual timer block against a counting model over apb
// assumes the pin partner and the checker are compiled first
`timescale 1ns/1ps
`include "dtc_map.vh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module dual_timer_counter_test;
   logic        clk_in = 0;   // 50 MHz clock
   logic        rst_b = 0;    // reset, active low
   logic        psel = 0;     // apb select
   logic        pen = 0;      // apb enable
   logic        pwr = 0;      // apb direction
   logic [11:0] paddr = 0;    // apb address
   logic [31:0] pwdata = 0;   // apb write data
   logic [3:0]  ack = 0;      // vector acknowledges
   wire  [31:0] prdata;       // apb read data
   wire         pready;       // apb ready
   wire         pslverr;      // apb error
   wire  [3:0]  flags;        // ext1 ext0 ovf1 ovf0
   wire  [1:0]  cnt_pin;      // count pins
   wire  [1:0]  irq_pin;      // irq and gate pins
   logic [31:0] rd;           // last read data
   logic        err;          // last error response
   logic [16:0] exp_v;        // model flag and count
   logic [15:0] st[4] = '{16'hFF1C, 16'hFFFC, 16'h40FC, 16'h77FC}; // start per mode
   integer      seed = 90;
   int          error_cnt = 0, tests_run = 0, cycles = 0, n, h;
   always #10 clk_in = ~clk_in;
   dtc_top dut (.CLK_IN(clk_in), .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
      .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .COUNT_INPUT_PIN_ZERO_IN(cnt_pin[0]),
      .COUNT_INPUT_PIN_ONE_IN(cnt_pin[1]), .EXTERNAL_IRQ_PIN_ZERO_IN(irq_pin[0]),
      .EXTERNAL_IRQ_PIN_ONE_IN(irq_pin[1]), .VECTOR_ACK_IN(ack),
      .OVERFLOW_FLAG_ZERO_OUT(flags[0]), .OVERFLOW_FLAG_ONE_OUT(flags[1]),
      .EXT_IRQ_FLAG_ZERO_OUT(flags[2]), .EXT_IRQ_FLAG_ONE_OUT(flags[3]));
   dtc_pins_model p (.clk_in(clk_in), .cnt_pin_out(cnt_pin), .irq_pin_out(irq_pin));
   // reference count after n events
   function automatic logic [16:0] model(int t, int m, logic [15:0] v, int n);
      logic f;
      f = 0;
      repeat (n) begin
         case (m)
            0: begin
               v[4:0] = v[4:0] + 5'h1;
               if (v[4:0] == 5'h0) v[15:8] = v[15:8] + 8'h1;
               f = f | (v[4:0] == 5'h0 && v[15:8] == 8'h0);
            end
            1: begin
               v = v + 16'h1;
               f = f | (v == 16'h0);
            end
            2: begin
               v[7:0] = v[7:0] + 8'h1;
               if (v[7:0] == 8'h0) begin
                  v[7:0] = v[15:8];
                  f = 1;
               end
            end
            default: if (t == 0) begin
               v[7:0] = v[7:0] + 8'h1;
               f = f | (v[7:0] == 8'h0);
            end
         endcase
      end
      return {f, v};
   endfunction
   // one apb transfer, waits for ready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_in);
      pen <= 1;
      @(posedge clk_in);
      while (pready !== 1'b1) @(posedge clk_in);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      pen <= 0;
   endtask
   // one-cycle vector acknowledge, then settle
   task vack(input int i);
      @(posedge clk_in);
      ack[i] <= 1'b1;
      @(posedge clk_in);
      ack[i] <= 1'b0;
      repeat (3) @(posedge clk_in);
   endtask
   task summarize;
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // hang guard
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   initial begin
      repeat (3) @(posedge clk_in);
      rst_b <= 1'b1;
      for (int a = 0; a < 6; a++) begin
         apb(0, 12'(a * 4), 32'h0);
         `CHK("reset read", 32'h0, rd)
         `CHK("error response", a == 5, err)
      end
      apb(1, `DTC_OFS_ACK, 32'hFFFF_FFFF);
      `CHK("unmapped write error", 1'b1, err)
      $display("test registers done");
      for (int t = 0; t < 2; t++) begin
         for (int m = 0; m < 4; m++) begin
            n = 3 + {$random(seed)} % 4;
            h = 2 + {$random(seed)} % 2;
            exp_v = model(t, m, st[m], n);
            apb(1, `DTC_OFS_MODE, (32'h4 | m) << (4 * t));
            apb(1, `DTC_OFS_CNT0 + 12'(4 * t), {16'h0, st[m]});
            apb(1, `DTC_OFS_CTRL, 32'h10 << (2 * t));
            apb(0, `DTC_OFS_CNT0 + 12'(4 * t), 32'h0);
            `CHK("count after run", {16'h0, st[m]}, rd)
            p.pulse(t, n, h);
            repeat (4) @(posedge clk_in);
            apb(0, `DTC_OFS_CNT0 + 12'(4 * t), 32'h0);
            `CHK("count", {16'h0, exp_v[15:0]}, rd)
            `CHK("overflow flag", exp_v[16], flags[t])
            vack(t);
            `CHK("flag after vector", 1'b0, flags[t])
            apb(1, `DTC_OFS_CTRL, 32'h0);
            $display("test timer %0d mode %0d done", t, m);
         end
      end
      apb(1, `DTC_OFS_MODE, 32'h0000_000D);
      apb(1, `DTC_OFS_CNT0, 32'h0);
      apb(1, `DTC_OFS_CTRL, 32'h10);
      p.irq(0, 0);
      p.pulse(0, 3, 3);
      repeat (4) @(posedge clk_in);
      `CHK("level irq flag", 1'b1, flags[2])
      p.irq(0, 1);
      p.pulse(0, 2, 3);
      repeat (4) @(posedge clk_in);
      `CHK("level irq released", 1'b0, flags[2])
      apb(0, `DTC_OFS_CNT0, 32'h0);
      `CHK("gated count", 32'h2, rd)
      apb(1, `DTC_OFS_CTRL, 32'h1);
      p.irq(0, 0);
      repeat (4) @(posedge clk_in);
      p.irq(0, 1);
      repeat (4) @(posedge clk_in);
      `CHK("edge irq flag held", 1'b1, flags[2])
      vack(2);
      `CHK("edge flag after vector", 1'b0, flags[2])
      $display("test gate and irq done");
      apb(1, `DTC_OFS_MODE, 32'h0000_0003);
      apb(1, `DTC_OFS_CNT0, 32'h0000_FF00);
      apb(1, `DTC_OFS_CTRL, 32'h40);
      p.irq(1, 0);
      repeat (30) @(posedge clk_in);
      `CHK("split high overflow", 1'b1, flags[1])
      `CHK("level irq flag one", 1'b1, flags[3])
      apb(0, `DTC_OFS_CNT0, 32'h0);
      `CHK("split low held", 8'h00, rd[7:0])
      $display("test split mode done");
      summarize();
   end
endmodule // dual_timer_counter_test
